// ### logic/jhcs_top.sv
// host command decode, configuration byte and status byte
// assumes command and data bytes arrive together as one strobe and the
// link transmitter and receiver sit outside this block
`timescale 1ns/1ps
import jhcs_pkg::*;
// Functional notes
// R01: final-byte load sets transmit fill state to full.
// R02: final byte dropped when queue empty or finished frame transmitting.
// R03: deferred config waits for bus idle; after reset waits 1.2 ms.
// R04: first-byte load sets transmit fill state to data present.
// R05: second first tag before final: halt, queue error code, drop rest.
// R06: first byte dropped while finished frame is transmitting.
// R07: first-and-last byte is one-byte frame; fill state becomes full.
// R08: first-and-last dropped when finished frame waits or transmits.
// R09: receive command 00 none, 01 reserved, 10 pop head, 11 flush.
// R10: head removal pops one entry, never queued, only code remover.
// R11: flush cycles queue to a completion code; interrupt when reached.
// R12: flush on empty or mid-frame discards bytes until the code.
// R13: configuration is write-only and held until rewritten or reset.
// R14: test select 00 normal, else test; test enable disables receive.
// R15: interrupt block bit disables interrupts and bus wake-up.
// R16: extra interrupt on byte arriving into empty receive queue.
// R17: divider codes 00..11 divide by 1..4; host picks 2 MHz result.
// R18: quad speed bit runs timing four times faster, no waveshaping.
// R19: parallel mode: status alone, data read pops the head.
// R20: serial mode: status and data paired, read does not pop.
// R21: status frozen while chip select low, updated when released.
// R22: receive state field encodes empty, counts and code positions.
// R23: destination field decodes none, data, final, config, first, both.
// R24: fill state 00 empty, 01 one to nine, 10 ten, 11 full.
// R25: reserved destination and receive codes do nothing.
module jhcs_top #(
   parameter int TXQ_DEPTH = 11,
   parameter int RXQ_DEPTH = 20,
   parameter int CFG_DELAY = jhcs_pkg::CFG_RESET_DELAY_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic host_cs_n,
   input wire logic host_serial_mode,
   input wire logic cmd_strobe,
   input wire logic [7:0] cmd_byte,
   input wire logic [7:0] cmd_data,
   input wire logic data_read,
   input wire logic rx_valid,
   input wire logic rx_is_code,
   input wire logic [7:0] rx_byte,
   input wire logic bus_idle,
   input wire logic net_fault,
   input wire logic tx_active,
   input wire logic tx_pop,
   input wire logic tx_pop_first,
   input wire logic tx_pop_last,
   output logic [7:0] status_byte,
   output logic [7:0] rx_data,
   output logic tx_load,
   output logic [7:0] tx_load_byte,
   output logic tx_load_first,
   output logic tx_load_last,
   output logic tx_halt,
   output logic int_req,
   output logic wake_enable,
   output logic test_mode,
   output logic rx_disable,
   output logic waveshape_off,
   output logic int_tick,
   output logic bit_tick
);
   import jhcs_pkg::*;

   localparam int TW = $clog2(TXQ_DEPTH + 1);
   localparam int RW = $clog2(RXQ_DEPTH + 1);
   localparam int DW = $clog2(CFG_DELAY + 1);
   if (TXQ_DEPTH <= TXQ_ALMOST_COUNT || RXQ_DEPTH < RXQ_THIRTEEN_COUNT
      || CFG_DELAY < 1) begin
      $error("jhcs_top parameters out of range");
   end

   // --------------------------------------------------------------
   // command decode
   // --------------------------------------------------------------
   jhcs_dest_t dest;
   jhcs_rxcmd_t rxcmd;
   logic [TW-1:0] tx_count;
   logic frame_done;
   logic in_frame;
   logic tx_empty;
   logic tx_full;
   logic sending_done;
   logic do_load;
   logic load_first;
   logic load_last;
   logic second_first;

   assign dest = jhcs_dest_t'(cmd_byte[DEST_MSB:DEST_LSB]);
   assign rxcmd = jhcs_rxcmd_t'(cmd_byte[RXCMD_MSB:RXCMD_LSB]);
   assign tx_empty = tx_count == '0;
   assign tx_full = tx_count == TW'(TXQ_DEPTH);
   assign sending_done = frame_done && tx_active;
   assign second_first = tx_pop && tx_pop_first && in_frame; // R05

   always_comb begin
      do_load = 1'b0;
      load_first = 1'b0;
      load_last = 1'b0;
      if (cmd_strobe && !second_first) begin
         case (dest) // R23
            DEST_DATA: begin
               do_load = !tx_full && !frame_done && !tx_empty;
            end
            DEST_LAST: begin
               do_load = !tx_full && !sending_done && !tx_empty; // R02
               load_last = 1'b1;
            end
            DEST_FIRST: begin
               do_load = !tx_full && !sending_done; // R06
               load_first = 1'b1;
            end
            DEST_ONLY: begin
               do_load = !tx_full && !frame_done; // R08
               load_first = 1'b1;
               load_last = 1'b1;
            end
            default: begin
               do_load = 1'b0; // R25
            end
         endcase
      end
   end

   // --------------------------------------------------------------
   // transmit queue tracking
   // --------------------------------------------------------------
   logic [TW-1:0] next_tx_count;
   logic [1:0] tx_fill;

   always_comb begin
      next_tx_count = tx_count + TW'(do_load) - TW'(tx_pop && !tx_empty);
      if (second_first) begin
         next_tx_count = '0; // R05
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_count <= '0;
      end else begin
         tx_count <= next_tx_count;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         frame_done <= 1'b0;
      end else if (do_load && load_last) begin
         frame_done <= 1'b1; // R01 R07
      end else if (next_tx_count == '0) begin
         frame_done <= 1'b0;
      end
   end

   // the transmitter reports the tag of each byte it takes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         in_frame <= 1'b0;
      end else if (second_first) begin
         in_frame <= 1'b0;
      end else if (tx_pop) begin
         in_frame <= (tx_pop_first || in_frame) && !tx_pop_last;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_load <= 1'b0;
         tx_load_byte <= 8'h00;
         tx_load_first <= 1'b0;
         tx_load_last <= 1'b0;
         tx_halt <= 1'b0;
      end else begin
         tx_load <= do_load;
         tx_load_byte <= cmd_data;
         tx_load_first <= load_first;
         tx_load_last <= load_last;
         tx_halt <= second_first; // R05
      end
   end

   always_comb begin
      if (frame_done || tx_full) begin
         tx_fill = TXQ_FULL; // R01 R07 R24
      end else if (tx_empty) begin
         tx_fill = TXQ_EMPTY;
      end else if (tx_count == TW'(TXQ_ALMOST_COUNT)) begin
         tx_fill = TXQ_ALMOST;
      end else begin
         tx_fill = TXQ_DATA; // R04
      end
   end

   // --------------------------------------------------------------
   // configuration byte
   // --------------------------------------------------------------
   logic [7:0] cfg;
   logic [7:0] cfg_pending;
   logic pend;
   logic after_reset;
   logic [DW-1:0] delay_cnt;
   logic apply_pending;

   assign apply_pending = pend && (after_reset ?
      delay_cnt >= DW'(CFG_DELAY) : bus_idle); // R03

   // the reset hold-off is a one-shot: an immediate config write or the first applied deferred one ends it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         after_reset <= 1'b1;
      end else if (apply_pending || (cmd_strobe && dest == DEST_CFG_NOW))
      begin
         after_reset <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         delay_cnt <= '0;
      end else if (cmd_strobe && dest == DEST_CFG) begin
         delay_cnt <= '0;
      end else if (pend && delay_cnt < DW'(CFG_DELAY)) begin
         delay_cnt <= delay_cnt + DW'(1);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pend <= 1'b0;
         cfg_pending <= CFG_RESET;
      end else if (cmd_strobe && dest == DEST_CFG) begin
         pend <= 1'b1;
         cfg_pending <= cmd_data;
      end else if (apply_pending
         || (cmd_strobe && dest == DEST_CFG_NOW)) begin
         pend <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg <= CFG_RESET; // R13
      end else if (cmd_strobe && dest == DEST_CFG_NOW) begin
         cfg <= cmd_data; // R03
      end else if (apply_pending) begin
         cfg <= cfg_pending; // R13
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wake_enable <= 1'b1;
         test_mode <= 1'b0;
         rx_disable <= 1'b0;
         waveshape_off <= 1'b0;
      end else begin
         wake_enable <= !cfg[CFG_INT_BLOCK]; // R15
         test_mode <= cfg[CFG_TSEL_MSB:CFG_TSEL_LSB] != TSEL_NORMAL; // R14
         rx_disable <= cfg[CFG_TEST_EN]; // R14
         waveshape_off <= cfg[CFG_QUAD]; // R18
      end
   end

   jhcs_clkdiv u_clkdiv (
      .clk(clk),
      .reset(reset),
      .div_sel(cfg[CFG_DIV_MSB:CFG_DIV_LSB]),
      .quad(cfg[CFG_QUAD]),
      .int_tick(int_tick),
      .bit_tick(bit_tick)
   );

   // --------------------------------------------------------------
   // receive queue and its commands
   // --------------------------------------------------------------
   logic [7:0] rxq_head;
   logic rxq_head_code;
   logic [RW-1:0] rxq_count;
   logic [RW-1:0] rxq_codes;
   logic code_pend;
   logic flushing;
   logic rx_push;
   logic rx_push_code;
   logic [7:0] rx_push_data;
   logic rx_pop;
   logic cmd_pop;

   // error code from the transmitter waits for a free push slot
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         code_pend <= 1'b0;
      end else if (second_first) begin
         code_pend <= 1'b1; // R05
      end else if (!rx_valid) begin
         code_pend <= 1'b0;
      end
   end

   assign rx_push = rx_valid || code_pend;
   assign rx_push_code = rx_valid ? rx_is_code : 1'b1;
   assign rx_push_data = rx_valid ? rx_byte : CODE_SECOND_FIRST;
   assign cmd_pop = cmd_strobe && rxcmd == RXC_POP; // R09 R10

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flushing <= 1'b0;
      end else if (cmd_strobe && rxcmd == RXC_FLUSH && !rxq_head_code) begin
         flushing <= 1'b1; // R11 R12
      end else if (rxq_head_code) begin
         flushing <= 1'b0; // R11
      end
   end

   // one pop per cycle: flush walk, head removal, or parallel read
   always_comb begin
      rx_pop = 1'b0;
      if (flushing) begin
         rx_pop = !rxq_head_code && rxq_count != '0; // R11 R12
      end else if (cmd_pop) begin
         rx_pop = 1'b1; // R10
      end else if (data_read && !host_serial_mode) begin
         rx_pop = !rxq_head_code; // R19 R20
      end
   end

   jhcs_rxq #(
      .WIDTH(8),
      .DEPTH(RXQ_DEPTH)
   ) u_rxq (
      .clk(clk),
      .reset(reset),
      .push(rx_push),
      .push_code(rx_push_code),
      .push_data(rx_push_data),
      .pop(rx_pop),
      .head(rxq_head),
      .head_code(rxq_head_code),
      .count(rxq_count),
      .codes(rxq_codes)
   );

   // --------------------------------------------------------------
   // interrupt request
   // --------------------------------------------------------------
   logic head_code_d;
   logic code_arrived;

   assign code_arrived = rxq_head_code && !head_code_d;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         head_code_d <= 1'b0;
      end else begin
         head_code_d <= rxq_head_code;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         int_req <= 1'b0;
      end else begin
         int_req <= !cfg[CFG_INT_BLOCK] && (code_arrived || // R15 R11
            (!flushing && cfg[CFG_EXTRA_INT] && rx_valid
            && rxq_count == '0)); // R16
      end
   end

   // --------------------------------------------------------------
   // status byte
   // --------------------------------------------------------------
   logic [2:0] rxq_state;
   logic [7:0] next_status;

   always_comb begin
      if (flushing || rxq_count == '0) begin
         rxq_state = RXQ_EMPTY; // R12 R22
      end else if (rxq_head_code) begin
         if (rxq_count == RW'(1)) begin
            rxq_state = RXQ_CODE_ONLY;
         end else if (rxq_codes > RW'(1)) begin
            rxq_state = RXQ_CODE_FRAME;
         end else begin
            rxq_state = RXQ_CODE_MORE;
         end
      end else if (rxq_codes != '0) begin
         rxq_state = RXQ_CODE_INSIDE;
      end else if (rxq_count == RW'(1)) begin
         rxq_state = RXQ_ONE;
      end else if (rxq_count >= RW'(RXQ_THIRTEEN_COUNT)) begin
         rxq_state = RXQ_THIRTEENTH;
      end else begin
         rxq_state = RXQ_SEVERAL; // R22
      end
   end

   always_comb begin
      next_status = STATUS_RESET;
      next_status[ST_RXQ_MSB:ST_RXQ_LSB] = rxq_state;
      next_status[ST_IDLE] = bus_idle;
      next_status[ST_NETF] = net_fault;
      next_status[ST_QUAD] = cfg[CFG_QUAD];
      next_status[ST_TXQ_MSB:ST_TXQ_LSB] = tx_fill;
   end

   // frozen during a host access so status and data stay paired
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status_byte <= STATUS_RESET;
         rx_data <= 8'h00;
      end else if (host_cs_n) begin
         status_byte <= next_status; // R21 R20
         rx_data <= rxq_head; // R22
      end
   end
endmodule

// ### logic/jhcs_pkg.sv
// constants for the host command, configuration and status logic
// assumes one 50 MHz clock shared by all design files
package jhcs_pkg;
   // --------------------------------------------------------------
   // clock and timing
   // --------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 20000;
   localparam int CFG_RESET_DELAY_US_X10 = 12; // 1.2 ms in 0.1 ms
   localparam int CFG_RESET_DELAY_CYCLES =
      (CFG_RESET_DELAY_US_X10 * 100000000 + CLK_PERIOD_PS - 1) /
      CLK_PERIOD_PS;
   // --------------------------------------------------------------
   // command byte fields
   // --------------------------------------------------------------
   localparam int DEST_MSB = 4;
   localparam int DEST_LSB = 2;
   localparam int RXCMD_MSB = 1;
   localparam int RXCMD_LSB = 0;
   typedef enum logic [2:0] {
      DEST_NONE = 3'h0, DEST_DATA = 3'h1, DEST_RSVD = 3'h2,
      DEST_LAST = 3'h3, DEST_CFG = 3'h4, DEST_FIRST = 3'h5,
      DEST_CFG_NOW = 3'h6, DEST_ONLY = 3'h7
   } jhcs_dest_t;
   typedef enum logic [1:0] {
      RXC_NONE = 2'h0, RXC_RSVD = 2'h1, RXC_POP = 2'h2, RXC_FLUSH = 2'h3
   } jhcs_rxcmd_t;
   // --------------------------------------------------------------
   // configuration byte fields
   // --------------------------------------------------------------
   localparam int CFG_TEST_EN = 7;
   localparam int CFG_TSEL_MSB = 6;
   localparam int CFG_TSEL_LSB = 5;
   localparam int CFG_INT_BLOCK = 4;
   localparam int CFG_EXTRA_INT = 3;
   localparam int CFG_DIV_MSB = 2;
   localparam int CFG_DIV_LSB = 1;
   localparam int CFG_QUAD = 0;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [1:0] TSEL_NORMAL = 2'h0;
   // --------------------------------------------------------------
   // status byte fields and encodings
   // --------------------------------------------------------------
   localparam int ST_RXQ_MSB = 7;
   localparam int ST_RXQ_LSB = 5;
   localparam int ST_IDLE = 4;
   localparam int ST_NETF = 3;
   localparam int ST_QUAD = 2;
   localparam int ST_TXQ_MSB = 1;
   localparam int ST_TXQ_LSB = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [2:0] RXQ_EMPTY = 3'h0;
   localparam logic [2:0] RXQ_SEVERAL = 3'h1;
   localparam logic [2:0] RXQ_CODE_INSIDE = 3'h2;
   localparam logic [2:0] RXQ_THIRTEENTH = 3'h3;
   localparam logic [2:0] RXQ_ONE = 3'h4;
   localparam logic [2:0] RXQ_CODE_MORE = 3'h5;
   localparam logic [2:0] RXQ_CODE_FRAME = 3'h6;
   localparam logic [2:0] RXQ_CODE_ONLY = 3'h7;
   localparam int RXQ_THIRTEEN_COUNT = 13;
   localparam logic [1:0] TXQ_EMPTY = 2'h0;
   localparam logic [1:0] TXQ_DATA = 2'h1;
   localparam logic [1:0] TXQ_ALMOST = 2'h2;
   localparam logic [1:0] TXQ_FULL = 2'h3;
   localparam int TXQ_ALMOST_COUNT = 10;
   // completion code: error flag set, transmitter outcome 10
   localparam logic [7:0] CODE_SECOND_FIRST = 8'ha0;
endpackage

// ### logic/jhcs_clkdiv.sv
// internal clock divider and bus timing tick
// assumes the external clock is clk; ticks are one-cycle enables
`timescale 1ns/1ps
module jhcs_clkdiv (
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] div_sel,
   input wire logic quad,
   output logic int_tick,
   output logic bit_tick
);
   logic [1:0] div_cnt;
   logic [1:0] quarter;

   // divide by div_sel + 1
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_cnt <= 2'h0;
         int_tick <= 1'b0;
      end else if (div_cnt >= div_sel) begin // R17
         div_cnt <= 2'h0;
         int_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 2'h1;
         int_tick <= 1'b0;
      end
   end

   // normal timing uses one tick in four; quad speed uses all
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         quarter <= 2'h0;
         bit_tick <= 1'b0;
      end else begin
         if (int_tick) begin
            quarter <= quarter + 2'h1;
         end
         bit_tick <= int_tick && (quad || quarter == 2'h3); // R18
      end
   end
endmodule

// ### logic/jhcs_rxq.sv
// receive queue: data bytes and completion codes with a code marker
// assumes push and pop are single-cycle strobes from the parent
`timescale 1ns/1ps
module jhcs_rxq #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 20
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic push,
   input wire logic push_code,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   output logic [WIDTH-1:0] head,
   output logic head_code,
   output logic [$clog2(DEPTH+1)-1:0] count,
   output logic [$clog2(DEPTH+1)-1:0] codes
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   if (DEPTH < 2 || WIDTH < 1) begin
      $error("receive queue needs depth of 2 or more");
   end

   logic [WIDTH:0] mem [DEPTH];
   logic [PW-1:0] rd_ptr;
   logic [PW-1:0] wr_ptr;
   logic do_push;
   logic do_pop;

   function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
      if (p == PW'(DEPTH - 1)) begin
         return '0;
      end
      return p + PW'(1);
   endfunction

   // a full queue drops new entries unless a pop frees a slot in the same cycle; earlier bytes stay put
   assign do_pop = pop && count != '0;
   assign do_push = push && (count != CW'(DEPTH) || do_pop);
   assign head = mem[rd_ptr][WIDTH-1:0];
   assign head_code = count != '0 && mem[rd_ptr][WIDTH];

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr] <= {push_code, push_data};
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count <= '0;
         codes <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= wrap_inc(wr_ptr);
         end
         if (do_pop) begin
            rd_ptr <= wrap_inc(rd_ptr);
         end
         count <= count + CW'(do_push) - CW'(do_pop);
         codes <= codes + CW'(do_push && push_code) -
            CW'(do_pop && head_code);
      end
   end
endmodule

// ### verification/jhcs_monitor.sv
// port assertions for the host command block
// assumes binding into jhcs_top, one clock domain
`timescale 1ns/1ps
module jhcs_monitor (
   input wire logic clk,
   input wire logic reset,
   input wire logic host_cs_n,
   input wire logic cmd_strobe,
   input wire logic [7:0] cmd_byte,
   input wire logic [7:0] cmd_data,
   input wire logic bus_idle,
   input wire logic [7:0] status_byte,
   input wire logic [7:0] rx_data,
   input wire logic tx_load,
   input wire logic [7:0] tx_load_byte,
   input wire logic tx_load_first,
   input wire logic tx_load_last,
   input wire logic tx_halt,
   input wire logic wake_enable,
   input wire logic test_mode,
   input wire logic rx_disable,
   input wire logic waveshape_off
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // ------------------------------
   // port relations
   // ------------------------------
   a_load_cause: assert property (
      tx_load |-> $past(cmd_strobe) && $past(cmd_byte[2]))
      else $error("load without load code");
   a_noload_code: assert property (
      cmd_strobe && !cmd_byte[2] |=> !tx_load)
      else $error("load from no-load code");
   a_load_tags: assert property (
      tx_load |-> {tx_load_first, tx_load_last} == $past(cmd_byte[4:3]))
      else $error("load tags wrong");
   a_load_byte: assert property (
      tx_load |-> tx_load_byte == $past(cmd_data))
      else $error("load byte wrong");
   a_halt_noload: assert property (
      tx_halt |-> !tx_load)
      else $error("load beside halt");
   a_last_full: assert property (
      tx_load && tx_load_last && host_cs_n |=> status_byte[1:0] == 2'h3)
      else $error("fill state not full");
   // status may only move on an edge where chip select was high
   a_status_frozen: assert property (
      !host_cs_n && $past(!host_cs_n) |->
      $stable(status_byte) && $stable(rx_data))
      else $error("status moved under select");
   a_idle_shown: assert property (
      $past(host_cs_n) && !$past(reset) |-> status_byte[4] == $past(bus_idle))
      else $error("idle bit stale");
   a_cfg_now: assert property (
      cmd_strobe && cmd_byte[4:2] == 3'h6 |-> ##2
      {wake_enable, test_mode, rx_disable, waveshape_off} ==
      {!$past(cmd_data[4], 2), |$past(cmd_data[6:5], 2),
      $past(cmd_data[7], 2), $past(cmd_data[0], 2)})
      else $error("immediate config wrong");
   c_halt: cover property (tx_halt);
   c_last: cover property (tx_load && tx_load_last);
   c_cs: cover property (!host_cs_n ##1 host_cs_n);
endmodule
bind jhcs_top jhcs_monitor u_jhcs_monitor (.*);

// ### verification/jhcs_host_model.sv
// host side model: command strobes, data reads, chip select
// assumes callers start just after a clock edge
`timescale 1ns/1ps
module jhcs_host_model (
   input wire logic clk,
   output logic host_cs_n,
   output logic host_serial_mode,
   output logic cmd_strobe,
   output logic [7:0] cmd_byte,
   output logic [7:0] cmd_data,
   output logic data_read
);
   initial begin
      host_cs_n = 1'b1;
      host_serial_mode = 1'b0;
      cmd_strobe = 1'b0;
      cmd_byte = 8'h00;
      cmd_data = 8'h00;
      data_read = 1'b0;
   end
   // idle edge first, so a strobe never drops and rises at once
   task send(input logic [7:0] c, input logic [7:0] d);
      @(posedge clk);
      #1;
      cmd_byte = c;
      cmd_data = d;
      cmd_strobe = 1'b1;
      @(posedge clk);
      #1;
      cmd_strobe = 1'b0;
      cmd_byte = ~c;
      cmd_data = ~d;
   endtask
   task rd;
      @(posedge clk);
      #1;
      data_read = 1'b1;
      @(posedge clk);
      #1;
      data_read = 1'b0;
   endtask
endmodule

// ### verification/testbench.sv
// self-checking bench for the host command block
// assumes jhcs_top, its bound monitor and the host model
`timescale 1ns/1ps
module testbench;
   import jhcs_pkg::*;
   logic clk = 0, reset = 1, rx_valid = 0, rx_is_code = 0, bus_idle = 1;
   logic net_fault = 0, tx_active = 0, tx_pop = 0, tx_pop_first = 0;
   logic tx_pop_last = 0, host_cs_n, host_serial_mode, cmd_strobe;
   logic data_read, tx_load, tx_load_first, tx_load_last, tx_halt, int_req;
   logic wake_enable, test_mode, rx_disable, waveshape_off, int_tick;
   logic bit_tick;
   logic [7:0] rx_byte = 0, cmd_byte, cmd_data, status_byte, rx_data, b;
   logic [7:0] tx_load_byte;
   logic [31:0] seed = 32'hdbe058db;
   int miscompares = 0, samples_checked = 0, cyc = 0;
   jhcs_top #(.CFG_DELAY(20)) u_jhcs_top (.*);
   jhcs_host_model u_jhcs_host_model (.*);
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         $display("BAD %0t timeout", $time);
         end_sim();
      end
   end
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function automatic logic [7:0] gap_of(input int d, q, s);
      return 8'((d + 1) * ((s == 0 || q == 1) ? 1 : 4));
   endfunction
   task tk(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] want);
      samples_checked++;
      if (seen !== want) begin
         miscompares++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task cmd(input logic [7:0] c, input logic [7:0] d, input logic ld);
      u_jhcs_host_model.send(c, d);
      chk(tx_load, ld);
   endtask
   task push(input logic code, input logic [7:0] d);
      tk(1);
      rx_valid = 1;
      rx_is_code = code;
      rx_byte = d;
      tk(1);
      rx_valid = 0;
      rx_byte = ~d;
   endtask
   // capped so a dead divider cannot hang
   task gap(input logic s, output logic [7:0] k);
      for (int i = 0; i < 40 && (s ? bit_tick : int_tick) !== 1; i++) tk(1);
      for (k = 1; k < 40; k++) begin
         tk(1);
         if ((s ? bit_tick : int_tick) === 1) break;
      end
   endtask
   task end_sim;
      if (miscompares == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      tk(4);
      chk(wake_enable, 1);
      reset = 0;
      cmd(8'h18, 8'h68, 0);
      b = rnd();
      push(0, b);
      chk(int_req, 1);
      tk(1);
      chk(status_byte[7:5], RXQ_ONE);
      chk(rx_data, b);
      push(0, rnd());
      chk(int_req, 0);
      tk(1);
      chk(status_byte[7:5], RXQ_SEVERAL);
      u_jhcs_host_model.rd();
      tk(1);
      chk(status_byte[7:5], RXQ_ONE);
      u_jhcs_host_model.host_cs_n = 0;
      push(0, rnd());
      tk(2);
      chk(status_byte[7:5], RXQ_ONE);
      u_jhcs_host_model.host_cs_n = 1;
      tk(2);
      chk(status_byte[7:5], RXQ_SEVERAL);
      b = rnd();
      push(1, b);
      cmd(8'h01, 0, 0);
      tk(1);
      chk(status_byte[7:5], RXQ_CODE_INSIDE);
      cmd(8'h03, 0, 0);
      tk(3);
      chk(int_req, 1);
      tk(2);
      chk(status_byte[7:5], RXQ_CODE_ONLY);
      chk(rx_data, b);
      cmd(8'h02, 0, 0);
      tk(1);
      chk(status_byte[7:5], RXQ_EMPTY);
      cmd(8'h02, 0, 0);
      push(0, rnd());
      chk(int_req, 1);
      tk(1);
      chk(status_byte[7:5], RXQ_ONE);
      u_jhcs_host_model.rd();
      cmd(8'h14, rnd(), 1);
      tk(1);
      chk(status_byte[1:0], TXQ_DATA);
      for (int i = 0; i < 9; i++) cmd(8'h04, rnd(), 1);
      tk(1);
      chk(status_byte[1:0], TXQ_ALMOST);
      cmd(8'h0c, rnd(), 1);
      cmd(8'h1c, rnd(), 0);
      tx_active = 1;
      tx_pop = 1;
      tx_pop_first = 1;
      tk(1);
      tx_pop_first = 0;
      tk(2);
      tx_pop = 0;
      cmd(8'h14, rnd(), 0);
      cmd(8'h0c, rnd(), 0);
      tx_pop = 1;
      tk(7);
      tx_pop_last = 1;
      tk(1);
      tx_pop = 0;
      tx_active = 0;
      tk(1);
      chk(status_byte[1:0], TXQ_EMPTY);
      cmd(8'h0c, rnd(), 0);
      cmd(8'h1c, rnd(), 1);
      tk(1);
      chk(status_byte[1:0], TXQ_FULL);
      tx_pop_first = 1;
      tx_pop = 1;
      tk(1);
      tx_pop = 0;
      cmd(8'h14, rnd(), 1);
      cmd(8'h04, rnd(), 1);
      cmd(8'h14, rnd(), 1);
      tx_pop_last = 0;
      tx_pop = 1;
      tk(1);
      tx_pop_first = 0;
      tk(1);
      tx_pop_first = 1;
      tk(1);
      tx_pop = 0;
      chk(tx_halt, 1);
      tk(4);
      chk(rx_data, CODE_SECOND_FIRST);
      reset = 1;
      tk(2);
      reset = 0;
      cmd(8'h10, 8'h80, 0);
      tk(10);
      chk(rx_disable, 0);
      tk(12);
      chk(rx_disable, 1);
      bus_idle = 0;
      cmd(8'h10, 8'h00, 0);
      tk(5);
      chk(rx_disable, 1);
      bus_idle = 1;
      tk(3);
      chk(rx_disable, 0);
      for (int q = 0; q < 2; q++) begin
         for (int d = 0; d < 4; d++) begin
            cmd(8'h18, 8'(d * 2 + q + 16), 0);
            tk(20);
            gap(0, b);
            chk(b, gap_of(d, q, 0));
            gap(1, b);
            chk(b, gap_of(d, q, 1));
         end
      end
      end_sim();
   end
endmodule
